// *** rtl/qbpp_pkg.sv ***
package qbpp_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned IRQ_N = 4;

  // timing of the momentary strong high driver
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned STRONG_HIGH_PS = 8000;
  localparam int unsigned STRONG_HIGH_CYC_I =
    (STRONG_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BOOST_W = 2;
  localparam logic [BOOST_W-1:0] STRONG_HIGH_CYC =
    (STRONG_HIGH_CYC_I < 1) ? BOOST_W'(1) : BOOST_W'(STRONG_HIGH_CYC_I);

  // first-port bit positions of the alternate functions
  localparam int unsigned BIT_TIMER_TWO_IO = 0;
  localparam int unsigned BIT_TIMER_TWO_CAPTURE = 1;
  localparam int unsigned BIT_SERIAL_B_RX = 2;
  localparam int unsigned BIT_SERIAL_B_TX = 3;
  localparam int unsigned BIT_IRQ_BASE = 4;

  // pending vector order and edge sense, bit i maps to port bit BIT_IRQ_BASE+i
  localparam int unsigned IRQ_RISE_A = 0;
  localparam int unsigned IRQ_FALL_A = 1;
  localparam int unsigned IRQ_RISE_B = 2;
  localparam int unsigned IRQ_FALL_B = 3;
  localparam logic [IRQ_N-1:0] IRQ_RISING = 4'h5;

  // reset values
  localparam logic [PORT_W-1:0] LATCH_RST = 8'hFF;
  localparam logic [PORT_W-1:0] PINS_RST = 8'hFF;
  localparam logic [IRQ_N-1:0] SYNC_RST = 4'hF;
  localparam logic [IRQ_N-1:0] PEND_RST = 4'h0;
  localparam logic [BOOST_W-1:0] BOOST_RST = 2'h0;

  // drive state of one 8-bit quasi-bidirectional port
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] weak_pu;
  } qbpp_drive_t;

  typedef struct packed {
    logic [PORT_W-1:0] latch;
    logic [PORT_W-1:0] prev_eff;
    logic [PORT_W-1:0][BOOST_W-1:0] boost;
    logic [PORT_W-1:0] pins;
    qbpp_drive_t drv;
  } qbpp_port_t;

  typedef struct packed {
    qbpp_port_t a;
    qbpp_port_t b;
    logic [IRQ_N-1:0] sync1;
    logic [IRQ_N-1:0] sync2;
    logic [IRQ_N-1:0] sync3;
    logic [IRQ_N-1:0] pend;
  } qbpp_state_t;

  // result of one bit's drive step
  typedef struct packed {
    logic out;
    logic oe;
    logic weak_pu;
    logic [BOOST_W-1:0] boost;
  } qbpp_bit_t;

endpackage

// *** rtl/qbpp_port_pair.sv ***
`timescale 1ns/1ps
`default_nettype none

module qbpp_port_pair (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic port_a_wr,
  input wire logic [7:0] port_a_wdata,
  input wire logic port_b_wr,
  input wire logic [7:0] port_b_wdata,
  output logic [7:0] port_a_latch,
  output logic [7:0] port_a_read,
  output logic [7:0] port_b_latch,
  output logic [7:0] port_b_read,
  input wire logic timer_two_io_drive,
  input wire logic serial_b_transmit,
  output logic timer_two_io,
  output logic timer_two_capture_trigger,
  output logic serial_b_receive,
  input wire logic ext_access,
  input wire logic [7:0] high_address_byte,
  input wire logic [3:0] irq_clear,
  output logic [3:0] irq_pending,
  input wire logic [7:0] port_a_pin_in,
  output logic [7:0] port_a_pin_out,
  output logic [7:0] port_a_pin_oe,
  output logic [7:0] port_a_weak_pu,
  input wire logic [7:0] port_b_pin_in,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_b_pin_oe,
  output logic [7:0] port_b_weak_pu
);

  qbpp_pkg::qbpp_state_t state_q;
  qbpp_pkg::qbpp_state_t state_d;
  logic [7:0] alt_a;
  logic [7:0] eff_a;
  logic [7:0] eff_b;
  logic [7:0] force_b;
  logic [3:0] irq_pins;
  logic [3:0] edge_hit;

  // one bit of quasi-bidirectional drive, shared by both ports
  function automatic qbpp_pkg::qbpp_bit_t qb_step(
    input logic eff,
    input logic prev,
    input logic [qbpp_pkg::BOOST_W-1:0] boost,
    input logic forced
  );
    qbpp_pkg::qbpp_bit_t r;
    r.out = eff;
    r.oe = 1'b0;
    r.weak_pu = eff;
    r.boost = qbpp_pkg::BOOST_RST;
    if (forced)
    begin
      // address phase drives hard both ways, no pullup reliance
      r.oe = 1'b1;
    end
    else if (!eff)
    begin
      r.oe = 1'b1;
      r.weak_pu = 1'b0;
    end
    else if (!prev)
    begin
      r.oe = 1'b1;
      r.boost = qbpp_pkg::STRONG_HIGH_CYC - qbpp_pkg::BOOST_W'(1);
    end
    else if (boost != qbpp_pkg::BOOST_RST)
    begin
      r.oe = 1'b1;
      r.boost = boost - qbpp_pkg::BOOST_W'(1);
    end
    else
    begin
      // released: weak pullup only, pin readable as input
      r.oe = 1'b0;
    end
    return r;
  endfunction

  // peripherals gate the latch low, as a shared wired-and output
  always_comb
  begin
    alt_a = 8'hFF;
    alt_a[qbpp_pkg::BIT_TIMER_TWO_IO] = timer_two_io_drive;
    alt_a[qbpp_pkg::BIT_SERIAL_B_TX] = serial_b_transmit;
  end

  assign eff_a = state_q.a.latch & alt_a;
  assign force_b = ext_access ? 8'hFF : 8'h00;
  assign eff_b = ext_access ? high_address_byte : state_q.b.latch;
  assign irq_pins = port_a_pin_in[qbpp_pkg::BIT_IRQ_BASE +: qbpp_pkg::IRQ_N];

  // rising for irq 0 and 2, falling for irq 1 and 3
  always_comb
  begin
    for (int i = 0; i < qbpp_pkg::IRQ_N; i++)
    begin
      if (qbpp_pkg::IRQ_RISING[i])
      begin
        edge_hit[i] = state_q.sync2[i] & ~state_q.sync3[i];
      end
      else
      begin
        edge_hit[i] = ~state_q.sync2[i] & state_q.sync3[i];
      end
    end
  end

  always_comb
  begin
    qbpp_pkg::qbpp_bit_t ra;
    qbpp_pkg::qbpp_bit_t rb;
    ra = '0;
    rb = '0;
    state_d = state_q;
    if (port_a_wr)
    begin
      state_d.a.latch = port_a_wdata;
    end
    if (port_b_wr)
    begin
      state_d.b.latch = port_b_wdata;
    end
    state_d.a.prev_eff = eff_a;
    state_d.b.prev_eff = eff_b;
    for (int i = 0; i < qbpp_pkg::PORT_W; i++)
    begin
      ra = qb_step(eff_a[i], state_q.a.prev_eff[i], state_q.a.boost[i], 1'b0);
      rb = qb_step(eff_b[i], state_q.b.prev_eff[i], state_q.b.boost[i], force_b[i]);
      state_d.a.drv.out[i] = ra.out;
      state_d.a.drv.oe[i] = ra.oe;
      state_d.a.drv.weak_pu[i] = ra.weak_pu;
      state_d.a.boost[i] = ra.boost;
      state_d.b.drv.out[i] = rb.out;
      state_d.b.drv.oe[i] = rb.oe;
      state_d.b.drv.weak_pu[i] = rb.weak_pu;
      state_d.b.boost[i] = rb.boost;
    end
    // pins are synchronous; one register stage gives clean read data
    state_d.a.pins = port_a_pin_in;
    state_d.b.pins = port_b_pin_in;
    state_d.sync1 = irq_pins;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    // a new edge beats a clear in the same cycle
    state_d.pend = (state_q.pend & ~irq_clear) | edge_hit;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q.a.latch <= qbpp_pkg::LATCH_RST;
      state_q.b.latch <= qbpp_pkg::LATCH_RST;
      state_q.a.prev_eff <= qbpp_pkg::LATCH_RST;
      state_q.b.prev_eff <= qbpp_pkg::LATCH_RST;
      state_q.a.boost <= '0;
      state_q.b.boost <= '0;
      state_q.a.pins <= qbpp_pkg::PINS_RST;
      state_q.b.pins <= qbpp_pkg::PINS_RST;
      state_q.a.drv.out <= qbpp_pkg::LATCH_RST;
      state_q.a.drv.oe <= '0;
      state_q.a.drv.weak_pu <= qbpp_pkg::LATCH_RST;
      state_q.b.drv.out <= qbpp_pkg::LATCH_RST;
      state_q.b.drv.oe <= '0;
      state_q.b.drv.weak_pu <= qbpp_pkg::LATCH_RST;
      // syncs start high so a pulled-up pin gives no false edge at release
      state_q.sync1 <= qbpp_pkg::SYNC_RST;
      state_q.sync2 <= qbpp_pkg::SYNC_RST;
      state_q.sync3 <= qbpp_pkg::SYNC_RST;
      state_q.pend <= qbpp_pkg::PEND_RST;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
    end
  end

  assign port_a_latch = state_q.a.latch;
  assign port_b_latch = state_q.b.latch;
  assign port_a_read = state_q.a.pins;
  assign port_b_read = state_q.b.pins;
  assign timer_two_io = state_q.a.pins[qbpp_pkg::BIT_TIMER_TWO_IO];
  assign timer_two_capture_trigger = state_q.a.pins[qbpp_pkg::BIT_TIMER_TWO_CAPTURE];
  assign serial_b_receive = state_q.a.pins[qbpp_pkg::BIT_SERIAL_B_RX];
  assign irq_pending = state_q.pend;
  assign port_a_pin_out = state_q.a.drv.out;
  assign port_a_pin_oe = state_q.a.drv.oe;
  assign port_a_weak_pu = state_q.a.drv.weak_pu;
  assign port_b_pin_out = state_q.b.drv.out;
  assign port_b_pin_oe = state_q.b.drv.oe;
  assign port_b_weak_pu = state_q.b.drv.weak_pu;

endmodule

`default_nettype wire

// *** verification/qbpp_port_pair_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module qbpp_port_pair_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] port_a_latch,
  input wire logic [7:0] port_a_read,
  input wire logic [7:0] port_b_read,
  input wire logic serial_b_transmit,
  input wire logic serial_b_receive,
  input wire logic ext_access,
  input wire logic [7:0] high_address_byte,
  input wire logic [3:0] irq_clear,
  input wire logic [3:0] irq_pending,
  input wire logic [7:0] port_a_pin_in,
  input wire logic [7:0] port_b_pin_in,
  input wire logic [7:0] port_a_pin_out,
  input wire logic [7:0] port_a_pin_oe,
  input wire logic [7:0] port_a_weak_pu,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_pull_low: assert property (
    !$past(port_a_latch[2]) |-> port_a_pin_oe[2] && !port_a_pin_out[2]) else $error("no pulldown");
  a_boost_two: assert property (
    $rose(port_a_latch[2]) |-> ##1 (port_a_pin_oe[2] && port_a_pin_out[2]) [*2]
    ##1 !port_a_pin_oe[2]) else $error("bad boost");
  a_weak_high: assert property (
    port_a_latch[2] [*4] |-> !port_a_pin_oe[2] && port_a_weak_pu[2]) else $error("not weak");
  a_reset_ones: assert property (disable iff (1'b0)
    srst |=> port_a_latch == 8'hFF && port_a_weak_pu == 8'hFF && irq_pending == 4'h0)
    else $error("bad reset");
  a_read_pins: assert property (
    !$past(srst) |-> port_b_read == $past(port_b_pin_in)
    && serial_b_receive == $past(port_a_pin_in[2])) else $error("bad read");
  a_tx_and: assert property (
    !$past(serial_b_transmit) |-> port_a_pin_oe[3] && !port_a_pin_out[3]) else $error("tx");
  a_addr_out: assert property (
    $past(ext_access) |-> port_b_pin_oe == 8'hFF && port_b_pin_out == $past(high_address_byte))
    else $error("bad address");
  a_rise_set: assert property (
    $rose(port_a_pin_in[4]) |-> ##3 irq_pending[0]) else $error("rise lost");
  a_fall_set: assert property (
    $fell(port_a_pin_in[5]) |-> ##3 irq_pending[1]) else $error("fall lost");
  a_flag_held: assert property (
    irq_pending[1] && !irq_clear[1] |=> irq_pending[1]) else $error("flag lost");
  cover property ($rose(irq_pending[0]));
  cover property ($rose(port_a_latch[2]));
  cover property (ext_access);
endmodule
`default_nettype wire

// *** verification/qbpp_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module qbpp_board (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pu,
  input wire logic [7:0] xen,
  input wire logic [7:0] xval,
  output logic [7:0] pin
);
  logic [7:0] last_q;
  always_ff @(posedge clk) last_q <= pin;
  // undriven line shows the inverse, so a stale value never passes
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin[i] = oe[i] ? out[i] : xen[i] ? xval[i] : pu[i] ? 1'b1 : ~last_q[i];
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, srst = 1, wa = 0, wb = 0, drv = 1, tx = 1, ext = 0, en = 1;
  logic [7:0] da = 0, db = 0, hab = 0, axe = 0, axv = 0, bxe = 0, bxv = 0, r;
  logic [3:0] clr = 0;
  wire logic [7:0] al, ar, bl, br, ao, aoe, apu, bo, boe, bpu, ap, bp;
  wire logic [3:0] pd;
  wire logic t2, t2c, rx;
  int bad_count = 0, total_checks = 0;
  logic [31:0] rs = 32'h2B9AB626;
  logic [10:0] q[$], nq;
  event ev;
  qbpp_port_pair u_qbpp_port_pair (.clk(clk), .srst(srst), .clk_en(en),
    .port_a_wr(wa), .port_a_wdata(da), .port_b_wr(wb), .port_b_wdata(db),
    .port_a_latch(al), .port_a_read(ar), .port_b_latch(bl), .port_b_read(br),
    .timer_two_io_drive(drv), .serial_b_transmit(tx), .timer_two_io(t2),
    .timer_two_capture_trigger(t2c), .serial_b_receive(rx), .ext_access(ext),
    .high_address_byte(hab), .irq_clear(clr), .irq_pending(pd), .port_a_pin_in(ap),
    .port_a_pin_out(ao), .port_a_pin_oe(aoe), .port_a_weak_pu(apu), .port_b_pin_in(bp),
    .port_b_pin_out(bo), .port_b_pin_oe(boe), .port_b_weak_pu(bpu));
  qbpp_board u_qbpp_board (.clk(clk), .out(ao), .oe(aoe), .pu(apu), .xen(axe), .xval(axv),
    .pin(ap));
  qbpp_board u_qbpp_board_1 (.clk(clk), .out(bo), .oe(boe), .pu(bpu), .xen(bxe), .xval(bxv),
    .pin(bp));
  initial forever #2 clk = ~clk;
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic logic [7:0] obs(logic [2:0] s);
    case (s)
      0: return ar;
      1: return br;
      2: return {4'h0, pd};
      3: return bo;
      4: return {5'h00, rx, t2c, t2};
      5: return bl;
      default: return bpu;
    endcase
  endfunction
  task automatic w(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic note(logic [2:0] s, logic [7:0] e);
    q.push_back({s, e});
    ->ev;
  endtask
  task automatic cmp8(logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial forever
  begin
    @ev;
    while (q.size() > 0)
    begin
      nq = q.pop_front();
      cmp8(nq[7:0], obs(nq[10:8]));
    end
  end
  initial
  begin
    repeat (4000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    w(20);
    srst = 0;
    w(1);
    note(0, 8'hFF);
    note(1, 8'hFF);
    note(6, 8'hFF);
    note(2, 8'h00);
    $display("reset test done");
    wa = 1;
    w(1);
    da = 8'hFF;
    w(1);
    wa = 0;
    w(4);
    note(0, 8'hFF);
    for (int k = 0; k < 4; k++)
    begin
      r = (k == 3) ? 8'hFF : rnd();
      {wa, wb, da, db} = {2'h3, r, r};
      w(1);
      {wa, wb} = 2'h0;
      w(4);
      note(0, r);
      note(1, r);
      note(5, r);
    end
    $display("write test done");
    r = rnd();
    {axe, axv, bxe, bxv} = {8'hFF, r, 8'hFF, r};
    w(3);
    note(0, r);
    note(1, r);
    note(4, {5'h00, r[2:0]});
    {axe, bxe, tx, drv} = {16'h0000, 2'h0};
    w(5);
    note(0, 8'hF6);
    {tx, drv, clr} = {2'h3, 4'hF};
    w(1);
    clr = 4'h0;
    $display("input test done");
    for (int i = 0; i < 4; i++)
    begin
      axv = 8'h00;
      axe[4 + i] = 1'b1;
      w(5);
      if (qbpp_pkg::IRQ_RISING[i])
      begin
        axv = 8'hFF;
        w(5);
      end
      note(2, 8'(1 << i));
      axe = 8'h00;
      clr = 4'(1 << i);
      w(1);
      clr = 4'h0;
      w(4);
      note(2, 8'h00);
    end
    $display("irq test done");
    hab = rnd();
    ext = 1;
    w(3);
    note(3, hab);
    ext = 0;
    $display("address test done");
    // enable low: a write must not reach the latch
    {en, wb, db} = {2'h1, 8'h00};
    w(2);
    note(5, 8'hFF);
    {en, wb} = 2'h2;
    $display("freeze test done");
    w(3);
    print_verdict();
  end
endmodule
bind qbpp_port_pair qbpp_port_pair_assertions u_qbpp_port_pair_assertions (.*);
`default_nettype wire
